// ### fum_pkg.sv
// constants, encodings and types shared by the float move unit
package fum_pkg;

	// datapath shape
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int NREG = 8;
	localparam int IDX_W = 3;
	localparam int LOC_W = 8;

	// opcode patterns of the lower opcode word
	localparam logic [7:0] OPC_ABS_STORE = 8'hBD;
	localparam logic [7:0] OPC_ABS_LOAD = 8'hBF;
	localparam logic [15:0] OPC_MEM_STORE = 16'hE203;
	localparam logic [15:0] OPC_STF_STORE = 16'hE200;
	// upper word bits 15:3 all ones mark the register-to-accumulator form
	localparam logic [12:0] ACCMV_TAG = 13'h1FFF;

	// float status register bit positions
	localparam int STF_LVF = 0;
	localparam int STF_LUF = 1;
	localparam int STF_NF = 2;
	localparam int STF_ZF = 3;
	localparam int STF_NI = 4;
	localparam int STF_ZI = 5;
	localparam int STF_TF = 6;
	localparam logic [31:0] STF_MASK = 32'h0000_007F;
	localparam logic [31:0] STF_RESET = 32'h0000_0000;

	// register map, byte addresses on the slave port
	localparam int AV_ADDR_W = 6;
	localparam logic [5:0] REG_FR0 = 6'h00;
	localparam logic [5:0] REG_STF = 6'h20;
	localparam logic [5:0] REG_CTRL = 6'h24;
	localparam logic [5:0] REG_STAT = 6'h28;
	localparam logic [5:0] REG_ACC = 6'h2C;

	// control and status fields
	localparam int CTRL_EN = 0;
	localparam logic CTRL_EN_RESET = 1'b1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_ILLEGAL = 1;
	localparam int STAT_PROT = 2;

	// pipeline timing in clock cycles
	localparam int ABS_CYCLES = 2;
	localparam int SINGLE_CYCLES = 1;

	typedef enum logic [1:0] {
		FUM_IDLE = 2'b00,
		FUM_BUSY = 2'b01
	} fum_state_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_ABS_ST = 3'b001,
		OP_ABS_LD = 3'b010,
		OP_ACC_MV = 3'b011,
		OP_MEM_ST = 3'b100,
		OP_STF_ST = 3'b101
	} fum_op_t;

endpackage : fum_pkg

// ### fum_decode.sv
// instruction word decoder of the float move unit
`timescale 1ns/10ps
module fum_decode (
	input wire logic [15:0] lsw,
	input wire logic [15:0] msw,
	output fum_pkg::fum_op_t op,
	output logic [fum_pkg::LOC_W-1:0] loc,
	output logic [fum_pkg::IDX_W-1:0] idx
);

	// classify the opcode pair and pull out its fields
	always_comb begin
		op = fum_pkg::OP_NONE;
		loc = lsw[7:0];
		idx = msw[10:8];
		if (lsw[15:8] == fum_pkg::OPC_ABS_STORE) begin
			op = fum_pkg::OP_ABS_ST;
		end else if (lsw[15:8] == fum_pkg::OPC_ABS_LOAD) begin
			if (msw[15:3] == fum_pkg::ACCMV_TAG) begin
				op = fum_pkg::OP_ACC_MV;
				idx = msw[2:0];
			end else begin
				op = fum_pkg::OP_ABS_LD;
			end
		end else if (lsw == fum_pkg::OPC_MEM_STORE && msw[15:11] == 5'h00) begin
			op = fum_pkg::OP_MEM_ST;
		end else if (lsw == fum_pkg::OPC_STF_STORE && msw[15:8] == 8'h00) begin
			op = fum_pkg::OP_STF_ST;
		end
	end

endmodule : fum_decode

// ### fum_core.sv
// float move unit: 32-bit moves between float registers, cpu locations and memory
//
// Contract
// - absolute store writes operand location word
// - protect bit never blocks absolute store
// - absolute store commits after two cycles
// - absolute store keeps float status flags
// - low half at address, high next
// - accumulator move copies whole float register
// - accumulator move sets cpu zero, negative
// - absolute load fills operand location word
// - absolute load to accumulator sets flags
// - absolute load result after two cycles
// - register store opcode decoded
// - register store one cycle, flags kept
// - status store opcode decoded
// - status store one cycle, flags kept
// - negative flag alone reads as four
// - three-bit index picks one of eight
// - absolute store opcode with address word
// - short address zero extended
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module fum_core #(
	parameter int ADDR_W = 24,
	parameter logic [7:0] LOC_ACC_CODE = 8'h00
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic INSN_VALID,
	input wire logic [15:0] INSN_LSW,
	input wire logic [15:0] INSN_MSW,
	output logic INSN_READY,
	input wire logic [31:0] LOC_RDATA,
	input wire logic [ADDR_W-1:0] MEMOP_ADDR,
	input wire logic PROT_WRITE_EN,
	output logic LOC_WR,
	output logic [7:0] LOC_SEL,
	output logic [31:0] LOC_WDATA,
	output logic ACC_WR,
	output logic [31:0] ACC_WDATA,
	output logic ST0_WR,
	output logic ST0_Z,
	output logic ST0_N,
	output logic MEM_WE,
	output logic MEM_RE,
	output logic [ADDR_W-1:0] MEM_ADDR_LO,
	output logic [ADDR_W-1:0] MEM_ADDR_HI,
	output logic [15:0] MEM_WDATA_LO,
	output logic [15:0] MEM_WDATA_HI,
	input wire logic [15:0] MEM_RDATA_LO,
	input wire logic [15:0] MEM_RDATA_HI,
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST
);

	localparam int ABS_LAT = fum_pkg::ABS_CYCLES;
	localparam int ONE_LAT = fum_pkg::SINGLE_CYCLES;

	// whole state of the unit
	typedef struct packed {
		fum_pkg::fum_state_t state;
		fum_pkg::fum_op_t op;
		logic [7:0] loc;
		logic [31:0] hold;
		logic [fum_pkg::NREG-1:0][31:0] fr;
		logic [31:0] float_status_register;
		logic en;
		logic illegal;
		logic prot_seen;
		logic [31:0] acc_last;
		logic mem_we;
		logic mem_re;
		logic [ADDR_W-1:0] mem_addr;
		logic [31:0] mem_wdata;
		logic loc_wr;
		logic [7:0] loc_sel;
		logic [31:0] loc_wdata;
		logic acc_wr;
		logic [31:0] acc_wdata;
		logic st0_wr;
		logic st0_z;
		logic st0_n;
		logic av_ack;
		logic [31:0] av_rdata;
	} fum_core_t;

	fum_core_t core_r;
	fum_core_t core_nxt;

	fum_pkg::fum_op_t dec_op;
	logic [7:0] dec_loc;
	logic [2:0] dec_idx;
	logic take;
	logic av_req;
	logic av_wr;
	logic [ADDR_W-1:0] short_absolute_address;
	logic [31:0] mem_rword;

	// byte-lane merge of a slave write
	function automatic logic [31:0] fum_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction : fum_merge

	fum_decode u_decode (
		.lsw(INSN_LSW),
		.msw(INSN_MSW),
		.op(dec_op),
		.loc(dec_loc),
		.idx(dec_idx)
	);

	// issue handshake and operand shaping
	assign INSN_READY = core_r.en && core_r.state == fum_pkg::FUM_IDLE;
	assign take = INSN_VALID && INSN_READY;
	assign short_absolute_address = {{(ADDR_W-16){1'b0}}, INSN_MSW};
	assign mem_rword = {MEM_RDATA_HI, MEM_RDATA_LO};
	assign av_req = (AVS_READ || AVS_WRITE) && !core_r.av_ack;
	assign av_wr = AVS_WRITE && core_r.av_ack;

	// next state of everything
	always_comb begin
		core_nxt = core_r;
		core_nxt.mem_we = 1'b0;
		core_nxt.mem_re = 1'b0;
		core_nxt.loc_wr = 1'b0;
		core_nxt.acc_wr = 1'b0;
		core_nxt.st0_wr = 1'b0;
		core_nxt.av_ack = av_req;
		case (core_r.state)
			fum_pkg::FUM_IDLE: begin
				if (take) begin
					case (dec_op)
						fum_pkg::OP_ABS_ST: begin
							// capture location word now, write next cycle
							core_nxt.hold = LOC_RDATA;
							core_nxt.mem_addr = short_absolute_address;
							core_nxt.op = dec_op;
							core_nxt.state = fum_pkg::FUM_BUSY;
							// protect bit only noted, never gates
							core_nxt.prot_seen = core_r.prot_seen || PROT_WRITE_EN;
						end
						fum_pkg::OP_ABS_LD: begin
							// read both halves, deliver next cycle
							core_nxt.mem_re = 1'b1;
							core_nxt.mem_addr = short_absolute_address;
							core_nxt.loc = dec_loc;
							core_nxt.op = dec_op;
							core_nxt.state = fum_pkg::FUM_BUSY;
						end
						fum_pkg::OP_ACC_MV: begin
							// full word to accumulator in one cycle
							core_nxt.acc_wr = 1'b1;
							core_nxt.acc_wdata = core_r.fr[dec_idx];
							core_nxt.acc_last = core_r.fr[dec_idx];
							core_nxt.st0_wr = 1'b1;
							core_nxt.st0_z = core_r.fr[dec_idx] == 32'h0000_0000;
							core_nxt.st0_n = core_r.fr[dec_idx][31];
						end
						fum_pkg::OP_MEM_ST: begin
							// one of eight registers, single cycle
							core_nxt.mem_we = 1'b1;
							core_nxt.mem_addr = MEMOP_ADDR;
							core_nxt.mem_wdata = core_r.fr[dec_idx];
						end
						fum_pkg::OP_STF_ST: begin
							// status word as held, single cycle
							core_nxt.mem_we = 1'b1;
							core_nxt.mem_addr = MEMOP_ADDR;
							core_nxt.mem_wdata = core_r.float_status_register & fum_pkg::STF_MASK;
						end
						default: begin
							core_nxt.illegal = 1'b1;
						end
					endcase
				end
			end
			fum_pkg::FUM_BUSY: begin
				// second cycle of the absolute moves
				core_nxt.state = fum_pkg::FUM_IDLE;
				if (core_r.op == fum_pkg::OP_ABS_ST) begin
					core_nxt.mem_we = 1'b1;
					core_nxt.mem_wdata = core_r.hold;
				end else begin
					core_nxt.loc_wr = 1'b1;
					core_nxt.loc_sel = core_r.loc;
					core_nxt.loc_wdata = mem_rword;
					if (core_r.loc == LOC_ACC_CODE) begin
						core_nxt.st0_wr = 1'b1;
						core_nxt.st0_z = mem_rword == 32'h0000_0000;
						core_nxt.st0_n = mem_rword[31];
						core_nxt.acc_last = mem_rword;
					end
				end
			end
			default: begin
				core_nxt.state = fum_pkg::FUM_IDLE;
			end
		endcase
		// register reads, latched on the wait cycle
		if (av_req) begin
			core_nxt.av_rdata = 32'h0000_0000;
			if (!AVS_ADDRESS[5]) begin
				core_nxt.av_rdata = core_r.fr[AVS_ADDRESS[4:2]];
			end else begin
				case (AVS_ADDRESS)
					fum_pkg::REG_STF: core_nxt.av_rdata = core_r.float_status_register & fum_pkg::STF_MASK;
					fum_pkg::REG_CTRL: core_nxt.av_rdata = {31'h0000_0000, core_r.en};
					fum_pkg::REG_STAT: core_nxt.av_rdata = {29'h0000_0000, core_r.prot_seen, core_r.illegal,
						core_r.state == fum_pkg::FUM_BUSY};
					fum_pkg::REG_ACC: core_nxt.av_rdata = core_r.acc_last;
					default: core_nxt.av_rdata = 32'h0000_0000;
				endcase
			end
		end
		// status flags change only by software writes
		if (av_wr) begin
			if (!AVS_ADDRESS[5]) begin
				core_nxt.fr[AVS_ADDRESS[4:2]] = fum_merge(core_r.fr[AVS_ADDRESS[4:2]], AVS_WRITEDATA, AVS_BYTEENABLE);
			end else begin
				case (AVS_ADDRESS)
					fum_pkg::REG_STF: begin
						core_nxt.float_status_register = fum_merge(core_r.float_status_register, AVS_WRITEDATA, AVS_BYTEENABLE) & fum_pkg::STF_MASK;
					end
					fum_pkg::REG_CTRL: begin
						if (AVS_BYTEENABLE[0]) begin
							core_nxt.en = AVS_WRITEDATA[fum_pkg::CTRL_EN];
						end
					end
					fum_pkg::REG_STAT: begin
						// write one clears, a new event in the same cycle wins
						if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[fum_pkg::STAT_ILLEGAL] && !core_nxt.illegal) begin
							core_nxt.illegal = 1'b0;
						end
						if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[fum_pkg::STAT_ILLEGAL] && core_r.illegal
							&& !(take && dec_op == fum_pkg::OP_NONE)) begin
							core_nxt.illegal = 1'b0;
						end
						if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[fum_pkg::STAT_PROT]
							&& !(take && dec_op == fum_pkg::OP_ABS_ST && PROT_WRITE_EN)) begin
							core_nxt.prot_seen = 1'b0;
						end
					end
					default: begin
						core_nxt.en = core_nxt.en;
					end
				endcase
			end
		end
	end

	// state register, synchronous reset
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			core_r <= '0;
			core_r.state <= fum_pkg::FUM_IDLE;
			core_r.op <= fum_pkg::OP_NONE;
			core_r.float_status_register <= fum_pkg::STF_RESET;
			core_r.en <= fum_pkg::CTRL_EN_RESET;
		end else begin
			core_r <= core_nxt;
		end
	end

	// outputs straight from the state register, except MEM_ADDR_HI, which is mem_addr plus one, and AVS_WAITREQUEST, which is av_req
	assign LOC_WR = core_r.loc_wr;
	assign LOC_SEL = core_r.loc_sel;
	assign LOC_WDATA = core_r.loc_wdata;
	assign ACC_WR = core_r.acc_wr;
	assign ACC_WDATA = core_r.acc_wdata;
	assign ST0_WR = core_r.st0_wr;
	assign ST0_Z = core_r.st0_z;
	assign ST0_N = core_r.st0_n;
	assign MEM_WE = core_r.mem_we;
	assign MEM_RE = core_r.mem_re;
	// low half at address, high half one above
	assign MEM_ADDR_LO = core_r.mem_addr;
	assign MEM_ADDR_HI = core_r.mem_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
	assign MEM_WDATA_LO = core_r.mem_wdata[15:0];
	assign MEM_WDATA_HI = core_r.mem_wdata[31:16];
	assign AVS_READDATA = core_r.av_rdata;
	assign AVS_WAITREQUEST = av_req;

	// alignment slots are left to the issuing side
	// checks of the move timing and data
	default clocking fum_cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	abs_store_data_a: assert property (
		(take && dec_op == fum_pkg::OP_ABS_ST) |-> ##ABS_LAT (MEM_WE && {MEM_WDATA_HI, MEM_WDATA_LO} == $past(LOC_RDATA, 2)))
		else $error("absolute store wrote wrong word");
	abs_store_prot_a: assert property (
		(take && dec_op == fum_pkg::OP_ABS_ST && PROT_WRITE_EN) |-> ##2 MEM_WE)
		else $error("protected absolute store dropped");
	abs_store_lat_a: assert property (
		(take && dec_op == fum_pkg::OP_ABS_ST) |=> (!MEM_WE && !INSN_READY) ##1 (MEM_WE && MEM_ADDR_LO == $past(MEM_ADDR_LO)))
		else $error("absolute store timing wrong");
	stf_hold_a: assert property (
		!(av_wr && AVS_ADDRESS == fum_pkg::REG_STF) |=> $stable(core_r.float_status_register))
		else $error("status flags changed by a move");
	half_order_a: assert property (
		(take && dec_op == fum_pkg::OP_MEM_ST) |=> (MEM_WDATA_LO == $past(core_r.fr[dec_idx][15:0])
			&& MEM_WDATA_HI == $past(core_r.fr[dec_idx][31:16]) && MEM_ADDR_HI == MEM_ADDR_LO + 1'b1))
		else $error("halves placed wrongly");
	acc_move_a: assert property (
		(take && dec_op == fum_pkg::OP_ACC_MV) |-> ##ONE_LAT (ACC_WR && ACC_WDATA == $past(core_r.fr[dec_idx])))
		else $error("accumulator move data wrong");
	acc_flags_a: assert property (
		ACC_WR |-> (ST0_WR && ST0_Z == (ACC_WDATA == 32'h0000_0000) && ST0_N == ACC_WDATA[31]))
		else $error("cpu flags wrong after accumulator move");
	abs_load_a: assert property (
		(take && dec_op == fum_pkg::OP_ABS_LD) |=> (MEM_RE && MEM_ADDR_LO == $past(short_absolute_address))
			##1 (LOC_WR && LOC_WDATA == $past(mem_rword)))
		else $error("absolute load data wrong");
	load_flags_a: assert property (
		LOC_WR |-> (ST0_WR == (LOC_SEL == LOC_ACC_CODE)))
		else $error("load flag update wrong");
	load_lat_a: assert property (
		(take && dec_op == fum_pkg::OP_ABS_LD) |=> !LOC_WR ##1 LOC_WR ##1 !LOC_WR)
		else $error("absolute load timing wrong");
	stf_store_a: assert property (
		(take && dec_op == fum_pkg::OP_STF_ST) |=> (MEM_WE && {MEM_WDATA_HI, MEM_WDATA_LO} == $past(core_r.float_status_register)))
		else $error("status store data wrong");
	av_wait_a: assert property (
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("slave wait too long");

	abs_store_c: cover property (take && dec_op == fum_pkg::OP_ABS_ST ##2 MEM_WE);
	abs_load_acc_c: cover property (LOC_WR && ST0_WR);
	acc_move_c: cover property (ACC_WR && ST0_N);
	stf_four_c: cover property (MEM_WE && {MEM_WDATA_HI, MEM_WDATA_LO} == 32'h0000_0004);

endmodule : fum_core

// ### fum_host.sv
// host model: word memory and cpu operand locations facing the float move unit
`timescale 1ns/10ps
module fum_host #(
	parameter int ADDR_W = 24
) (
	input wire logic core_clk,
	input wire logic insn_valid,
	input wire logic [15:0] insn_lsw,
	output logic [31:0] loc_rdata,
	input wire logic loc_wr,
	input wire logic [7:0] loc_sel,
	input wire logic [31:0] loc_wdata,
	input wire logic acc_wr,
	input wire logic [31:0] acc_wdata,
	input wire logic mem_we,
	input wire logic mem_re,
	input wire logic [ADDR_W-1:0] mem_addr_lo,
	input wire logic [ADDR_W-1:0] mem_addr_hi,
	input wire logic [15:0] mem_wdata_lo,
	input wire logic [15:0] mem_wdata_hi,
	output logic [15:0] mem_rdata_lo,
	output logic [15:0] mem_rdata_hi
);
	logic [15:0] mem [0:65535];
	logic [31:0] locs [0:255];
	logic [31:0] acc;
	always @(posedge core_clk) begin
		if (mem_we) begin
			mem[mem_addr_lo[15:0]] <= mem_wdata_lo;
			mem[mem_addr_hi[15:0]] <= mem_wdata_hi;
		end
		if (loc_wr) begin
			locs[loc_sel] <= loc_wdata;
		end
		if (acc_wr) begin
			acc <= acc_wdata;
		end
	end
	// idle lines show the inverse so stale data never looks valid
	assign mem_rdata_lo = mem_re ? mem[mem_addr_lo[15:0]] : ~mem[mem_addr_lo[15:0]];
	assign mem_rdata_hi = mem_re ? mem[mem_addr_hi[15:0]] : ~mem[mem_addr_hi[15:0]];
	assign loc_rdata = insn_valid ? locs[insn_lsw[7:0]] : ~locs[insn_lsw[7:0]];
endmodule : fum_host

// ### fum_core_bench.sv
// self-checking bench of the float move unit
`timescale 1ns/10ps
module fum_core_bench;
	logic core_clk = 1'b0, rst_n = 1'b0, insn_valid = 1'b0, prot_write_en = 1'b0;
	logic [15:0] insn_lsw = 16'h0000, insn_msw = 16'h0000;
	logic [23:0] memop_addr = 24'h00_0000;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, loc_rdata, loc_wdata, acc_wdata, rd;
	logic [3:0] avs_byteenable = 4'hF;
	logic insn_ready, loc_wr, acc_wr, st0_wr, st0_z, st0_n, mem_we, mem_re, avs_waitrequest;
	logic [7:0] loc_sel;
	logic [23:0] mem_addr_lo, mem_addr_hi;
	logic [15:0] mem_wdata_lo, mem_wdata_hi, mem_rdata_lo, mem_rdata_hi;
	int error_cnt = 0, total_checks = 0, cycles = 0;

	fum_core dut (.CORE_CLK(core_clk), .RST_N(rst_n), .INSN_VALID(insn_valid), .INSN_LSW(insn_lsw),
		.INSN_MSW(insn_msw), .INSN_READY(insn_ready), .LOC_RDATA(loc_rdata), .MEMOP_ADDR(memop_addr),
		.PROT_WRITE_EN(prot_write_en), .LOC_WR(loc_wr), .LOC_SEL(loc_sel), .LOC_WDATA(loc_wdata),
		.ACC_WR(acc_wr), .ACC_WDATA(acc_wdata), .ST0_WR(st0_wr), .ST0_Z(st0_z), .ST0_N(st0_n),
		.MEM_WE(mem_we), .MEM_RE(mem_re), .MEM_ADDR_LO(mem_addr_lo), .MEM_ADDR_HI(mem_addr_hi),
		.MEM_WDATA_LO(mem_wdata_lo), .MEM_WDATA_HI(mem_wdata_hi), .MEM_RDATA_LO(mem_rdata_lo),
		.MEM_RDATA_HI(mem_rdata_hi), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));

	fum_host host (.core_clk(core_clk), .insn_valid(insn_valid), .insn_lsw(insn_lsw),
		.loc_rdata(loc_rdata), .loc_wr(loc_wr), .loc_sel(loc_sel), .loc_wdata(loc_wdata),
		.acc_wr(acc_wr), .acc_wdata(acc_wdata), .mem_we(mem_we), .mem_re(mem_re),
		.mem_addr_lo(mem_addr_lo), .mem_addr_hi(mem_addr_hi), .mem_wdata_lo(mem_wdata_lo),
		.mem_wdata_hi(mem_wdata_hi), .mem_rdata_lo(mem_rdata_lo), .mem_rdata_hi(mem_rdata_hi));

	// 10 MHz clock
	always #50 core_clk = ~core_clk;

	// hang guard, the run needs under two hundred cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// test pattern of register i, zero for i = 0
	function automatic logic [31:0] fval(input int i);
		return 32'(32'h9234_ABC1 * i);
	endfunction : fval

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	// one bus cycle, held until waitrequest is sampled low
	task automatic av_xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : av_xfer

	// offer one instruction, return just after the edge that takes it
	task automatic issue(input logic [15:0] lsw, input logic [15:0] msw, input logic [23:0] ma);
		insn_valid <= 1'b1;
		insn_lsw <= lsw;
		insn_msw <= msw;
		memop_addr <= ma;
		do begin
			@(posedge core_clk);
		end while (insn_ready !== 1'b1);
		insn_valid <= 1'b0;
	endtask : issue

	task automatic t_regs;
		av_xfer(1'b0, fum_pkg::REG_CTRL, 32'h0000_0000);
		chk("ctrl reset", rd, 32'h0000_0001);
		for (int i = 0; i < 8; i++) begin
			av_xfer(1'b1, 6'(fum_pkg::REG_FR0 + 4 * i), fval(i));
		end
		av_xfer(1'b0, 6'h1C, 32'h0000_0000);
		chk("fr7 readback", rd, fval(7));
		av_xfer(1'b1, 6'h30, 32'hFFFF_FFFF);
		av_xfer(1'b0, 6'h30, 32'h0000_0000);
		chk("unmapped read", rd, 32'h0000_0000);
		$display("register access done");
	endtask : t_regs

	task automatic t_acc_move;
		logic [31:0] v;
		for (int i = 0; i < 8; i++) begin
			v = fval(i);
			repeat ((i == 7) ? 2 : 1) @(posedge core_clk);
			issue(16'hBF00, 16'(16'hFFF8 | i), 24'h00_0000);
			@(posedge core_clk);
			chk("acc write", {31'h0, acc_wr}, 32'h0000_0001);
			chk("acc data", acc_wdata, v);
			chk("st0 write", {31'h0, st0_wr}, 32'h0000_0001);
			chk("st0 zn", {30'h0, st0_z, st0_n}, {30'h0, v == 32'h0000_0000, v[31]});
		end
		@(posedge core_clk);
		chk("host acc", host.acc, fval(7));
		$display("accumulator move done");
	endtask : t_acc_move

	task automatic t_abs_store;
		av_xfer(1'b1, fum_pkg::REG_STF, 32'h0000_007F);
		host.locs[8'h21] = 32'h1234_ABCD;
		prot_write_en <= 1'b1;
		issue(16'hBD21, 16'hF000, 24'h00_0000);
		@(posedge core_clk);
		chk("store early", {31'h0, mem_we}, 32'h0000_0000);
		@(posedge core_clk);
		chk("store strobe", {31'h0, mem_we}, 32'h0000_0001);
		chk("addr lo", {8'h0, mem_addr_lo}, 32'h0000_F000);
		chk("addr hi", {8'h0, mem_addr_hi}, 32'h0000_F001);
		@(posedge core_clk);
		chk("mem word", {host.mem[16'hF001], host.mem[16'hF000]}, 32'h1234_ABCD);
		prot_write_en <= 1'b0;
		av_xfer(1'b0, fum_pkg::REG_STF, 32'h0000_0000);
		chk("flags kept", rd, 32'h0000_007F);
		$display("absolute store done");
	endtask : t_abs_store

	task automatic t_abs_load(input logic [7:0] loc);
		issue({8'hBF, loc}, 16'hF000, 24'h00_0000);
		@(posedge core_clk);
		chk("read strobe", {31'h0, mem_re}, 32'h0000_0001);
		chk("load early", {31'h0, loc_wr}, 32'h0000_0000);
		@(posedge core_clk);
		chk("load write", {31'h0, loc_wr}, 32'h0000_0001);
		chk("load sel", {24'h0, loc_sel}, {24'h0, loc});
		chk("load data", loc_wdata, 32'h1234_ABCD);
		chk("load st0", {30'h0, st0_wr, st0_n}, {30'h0, loc == 8'h00, 1'b0});
		@(posedge core_clk);
		chk("loc in host", host.locs[loc], 32'h1234_ABCD);
		$display("absolute load done");
	endtask : t_abs_load

	task automatic t_stores;
		av_xfer(1'b1, fum_pkg::REG_STF, 32'h0000_0004);
		issue(16'hE203, 16'h0540, 24'h00_0200);
		@(posedge core_clk);
		chk("reg store", {31'h0, mem_we}, 32'h0000_0001);
		chk("reg data", {mem_wdata_hi, mem_wdata_lo}, fval(5));
		chk("reg addr", {8'h0, mem_addr_lo}, 32'h0000_0200);
		issue(16'hE200, 16'h0040, 24'h00_0300);
		@(posedge core_clk);
		chk("stf store", {31'h0, mem_we}, 32'h0000_0001);
		chk("stf data", {mem_wdata_hi, mem_wdata_lo}, 32'h0000_0004);
		@(posedge core_clk);
		chk("stf in mem", {host.mem[16'h0301], host.mem[16'h0300]}, 32'h0000_0004);
		chk("reg in mem", {host.mem[16'h0201], host.mem[16'h0200]}, fval(5));
		av_xfer(1'b0, fum_pkg::REG_STF, 32'h0000_0000);
		chk("flags kept", rd, 32'h0000_0004);
		$display("register stores done");
	endtask : t_stores

	// sticky status bits, last accumulator value and the enable bit
	task automatic t_status;
		issue(16'h0000, 16'h0000, 24'h00_0000);
		av_xfer(1'b0, fum_pkg::REG_STAT, 32'h0000_0000);
		chk("sticky bits", rd, 32'h0000_0006);
		av_xfer(1'b1, fum_pkg::REG_STAT, 32'h0000_0006);
		av_xfer(1'b0, fum_pkg::REG_STAT, 32'h0000_0000);
		chk("sticky cleared", rd, 32'h0000_0000);
		av_xfer(1'b0, fum_pkg::REG_ACC, 32'h0000_0000);
		chk("last acc", rd, 32'h1234_ABCD);
		av_xfer(1'b1, fum_pkg::REG_CTRL, 32'h0000_0000);
		chk("ready when off", {31'h0, insn_ready}, 32'h0000_0000);
		av_xfer(1'b1, fum_pkg::REG_CTRL, 32'h0000_0001);
		chk("ready when on", {31'h0, insn_ready}, 32'h0000_0001);
		$display("status register done");
	endtask : t_status

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	// reset, then the scenarios in turn
	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		t_regs();
		t_acc_move();
		t_abs_store();
		repeat (2) @(posedge core_clk);
		t_abs_load(8'h00);
		t_abs_load(8'h05);
		t_stores();
		t_status();
		tally_and_finish();
	end
endmodule : fum_core_bench
